// ===== hw/ams_sequencer.sv
// Input multiplexer frame sequencer with its I/O RAM control registers
`timescale 1ns/1ps
`default_nettype none
`include "ams_consts.svh"

// Notes on behaviour
// - Inputs reach the converter one at a time; one pass is a frame.
// - Frame starts at first slot; after state-count slots converted it waits in tail until its last tick.
// - Three-input variant converts at most three slots per frame.
// - Four-input variant also allows a fourth slot per frame.
// - Frame lasts 13 slow-clock cycles; states begin on its rising edge.
module ams_sequencer #(
  parameter bit FourInput = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slowClock32k,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWriteData,
  input wire logic ioWrite,
  input wire logic ioRead,
  output logic [7:0] ioReadData,
  output ams_pkg::ams_conv_t conv,
  output logic frameStart,
  output logic slotStart,
  output ams_pkg::ams_cfg_t cfg
);
  import ams_pkg::*;

  // ----------------------------------------
  // Slow clock synchroniser and edge
  // ----------------------------------------
  logic ckSync1, ckSync2, ckSync3, ckLevel;
  logic next_ckLevel;
  logic tick;

  always_comb begin
    next_ckLevel = (ckSync2 == ckSync3) ? ckSync3 : ckLevel;
    tick = (ckSync2 == ckSync3) && ckSync3 && !ckLevel;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ckSync1 <= 1'b0;
      ckSync2 <= 1'b0;
      ckSync3 <= 1'b0;
      ckLevel <= 1'b0;
    end else begin
      ckSync1 <= slowClock32k;
      ckSync2 <= ckSync1;
      ckSync3 <= ckSync2;
      ckLevel <= next_ckLevel;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] frameCtrl, selUpper, selLower, equCfg, pairCfg, clkCfg, rmtCfg;
  logic [7:0] next_frameCtrl, next_selUpper, next_selLower, next_equCfg;
  logic [7:0] next_pairCfg, next_clkCfg, next_rmtCfg, next_ioReadData;
  ams_cfg_t next_cfg;
  ams_state_t state, next_state;
  logic [1:0] slot, next_slot;

  always_comb begin
    next_frameCtrl = frameCtrl;
    next_selUpper = selUpper;
    next_selLower = selLower;
    next_equCfg = equCfg;
    next_pairCfg = pairCfg;
    next_clkCfg = clkCfg;
    next_rmtCfg = rmtCfg;
    if (ioWrite) begin
      case (ioAddr)
        `AMS_ADDR_FRAME_CTRL: next_frameCtrl = ioWriteData;
        `AMS_ADDR_SEL_UPPER: next_selUpper = ioWriteData;
        `AMS_ADDR_SEL_LOWER: next_selLower = ioWriteData;
        `AMS_ADDR_EQU_CFG: next_equCfg = ioWriteData;
        `AMS_ADDR_PAIR_CFG: next_pairCfg = ioWriteData;
        `AMS_ADDR_CLK_CFG: next_clkCfg = ioWriteData;
        `AMS_ADDR_RMT_CFG: next_rmtCfg = ioWriteData;
        default: ;
      endcase
    end
    next_ioReadData = ioReadData;
    if (ioRead) begin
      case (ioAddr)
        `AMS_ADDR_FRAME_CTRL: next_ioReadData = frameCtrl;
        `AMS_ADDR_STATUS: next_ioReadData = {4'h0, state != AMS_IDLE, state == AMS_SLOT, slot};
        `AMS_ADDR_SEL_UPPER: next_ioReadData = selUpper;
        `AMS_ADDR_SEL_LOWER: next_ioReadData = selLower;
        `AMS_ADDR_EQU_CFG: next_ioReadData = equCfg;
        `AMS_ADDR_PAIR_CFG: next_ioReadData = pairCfg;
        `AMS_ADDR_CLK_CFG: next_ioReadData = clkCfg;
        `AMS_ADDR_RMT_CFG: next_ioReadData = rmtCfg;
        default: next_ioReadData = 8'h00;
      endcase
    end
    next_cfg.equationSelect = next_equCfg[`AMS_EQU_HI:`AMS_EQU_LO];
    next_cfg.chopMode = next_equCfg[`AMS_CHOP_HI:`AMS_CHOP_LO];
    next_cfg.filterLengthCode = next_pairCfg[`AMS_FIR_HI:`AMS_FIR_LO];
    next_cfg.firstPairDifferentialEnable = next_pairCfg[`AMS_DIFFA_BIT];
    next_cfg.secondPairDifferentialEnable = next_pairCfg[`AMS_DIFFB_BIT];
    next_cfg.halfRate = next_clkCfg[`AMS_HALF_BIT];
    next_cfg.fastPll = next_clkCfg[`AMS_FAST_BIT];
    next_cfg.remoteSensorEnable = next_rmtCfg[`AMS_RMT_BIT];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frameCtrl <= `AMS_REG_RESET;
      selUpper <= `AMS_REG_RESET;
      selLower <= `AMS_REG_RESET;
      equCfg <= `AMS_REG_RESET;
      pairCfg <= `AMS_REG_RESET;
      clkCfg <= `AMS_REG_RESET;
      rmtCfg <= `AMS_REG_RESET;
      ioReadData <= `AMS_REG_RESET;
      cfg <= '0;
    end else begin
      frameCtrl <= next_frameCtrl;
      selUpper <= next_selUpper;
      selLower <= next_selLower;
      equCfg <= next_equCfg;
      pairCfg <= next_pairCfg;
      clkCfg <= next_clkCfg;
      rmtCfg <= next_rmtCfg;
      ioReadData <= next_ioReadData;
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  logic [3:0] tickCnt, next_tickCnt;
  logic [1:0] slotTick, next_slotTick;
  logic [2:0] slotsInFrame, next_slotsInFrame;
  logic [3:0] stateCount;
  ams_conv_t next_conv;
  logic next_frameStart, next_slotStart;

  // Slot selects live two per byte, slot 0 in the low nibble of the lower byte
  function automatic logic [3:0] slotSource(input logic [1:0] idx, input logic [7:0] lo, input logic [7:0] hi);
    case (idx)
      2'h0: slotSource = lo[`AMS_SEL_EVEN_HI:`AMS_SEL_EVEN_LO];
      2'h1: slotSource = lo[`AMS_SEL_ODD_HI:`AMS_SEL_ODD_LO];
      2'h2: slotSource = hi[`AMS_SEL_EVEN_HI:`AMS_SEL_EVEN_LO];
      default: slotSource = hi[`AMS_SEL_ODD_HI:`AMS_SEL_ODD_LO];
    endcase
  endfunction : slotSource

  // Counts above the variant's input count are clipped, not wrapped
  function automatic logic [2:0] clampCount(input logic [3:0] cnt);
    logic [2:0] maxSlots;
    maxSlots = FourInput ? `AMS_MAX_SLOTS_FOUR : `AMS_MAX_SLOTS_THREE;
    clampCount = (cnt > {1'b0, maxSlots}) ? maxSlots : cnt[2:0];
  endfunction : clampCount

  always_comb begin
    stateCount = frameCtrl[`AMS_CNT_HI:`AMS_CNT_LO];
    next_state = state;
    next_tickCnt = tickCnt;
    next_slot = slot;
    next_slotTick = slotTick;
    next_slotsInFrame = slotsInFrame;
    next_frameStart = 1'b0;
    next_slotStart = 1'b0;
    if (tick) begin
      if (state == AMS_IDLE || tickCnt == `AMS_FRAME_TICKS - 4'h1) begin
        // Count sampled only at frame start, so a rewrite never cuts a frame
        if (stateCount != 4'h0) begin
          next_state = AMS_SLOT;
          next_tickCnt = 4'h0;
          next_slot = 2'h0;
          next_slotTick = 2'h0;
          next_slotsInFrame = clampCount(stateCount);
          next_frameStart = 1'b1;
          next_slotStart = 1'b1;
        end else begin
          next_state = AMS_IDLE;
        end
      end else begin
        next_tickCnt = tickCnt + 4'h1;
        case (state)
          AMS_SLOT: begin
            if (slotTick == `AMS_SLOT_TICKS - 2'h1) begin
              next_slotTick = 2'h0;
              if ({1'b0, slot} + 3'h1 == slotsInFrame) begin
                next_state = AMS_TAIL;
              end else begin
                next_slot = slot + 2'h1;
                next_slotStart = 1'b1;
              end
            end else begin
              next_slotTick = slotTick + 2'h1;
            end
          end
          AMS_TAIL: next_state = AMS_TAIL;
          default: next_state = AMS_IDLE;
        endcase
      end
    end
    next_conv.active = (next_state == AMS_SLOT);
    next_conv.slot = next_slot;
    next_conv.source = slotSource(next_slot, selLower, selUpper);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= AMS_IDLE;
      tickCnt <= 4'h0;
      slot <= 2'h0;
      slotTick <= 2'h0;
      slotsInFrame <= 3'h0;
      conv <= '0;
      frameStart <= 1'b0;
      slotStart <= 1'b0;
    end else begin
      state <= next_state;
      tickCnt <= next_tickCnt;
      slot <= next_slot;
      slotTick <= next_slotTick;
      slotsInFrame <= next_slotsInFrame;
      conv <= next_conv;
      frameStart <= next_frameStart;
      slotStart <= next_slotStart;
    end
  end

endmodule : ams_sequencer
`default_nettype wire

// ===== hw/ams_consts.svh
// Register offsets, field positions and frame timing of the input sequencer
`ifndef AMS_CONSTS_SVH
`define AMS_CONSTS_SVH

`define AMS_ADDR_FRAME_CTRL 16'h2100
`define AMS_ADDR_STATUS 16'h2101
`define AMS_ADDR_SEL_UPPER 16'h2104
`define AMS_ADDR_SEL_LOWER 16'h2105
`define AMS_ADDR_EQU_CFG 16'h2106
`define AMS_ADDR_PAIR_CFG 16'h210c
`define AMS_ADDR_CLK_CFG 16'h2200
`define AMS_ADDR_RMT_CFG 16'h2709

`define AMS_CNT_HI 7
`define AMS_CNT_LO 4
`define AMS_SEL_EVEN_HI 3
`define AMS_SEL_EVEN_LO 0
`define AMS_SEL_ODD_HI 7
`define AMS_SEL_ODD_LO 4
`define AMS_EQU_HI 7
`define AMS_EQU_LO 5
`define AMS_CHOP_HI 3
`define AMS_CHOP_LO 2
`define AMS_DIFFB_BIT 5
`define AMS_DIFFA_BIT 4
`define AMS_FIR_HI 2
`define AMS_FIR_LO 1
`define AMS_HALF_BIT 5
`define AMS_FAST_BIT 4
`define AMS_RMT_BIT 3

`define AMS_REG_RESET 8'h00
`define AMS_FRAME_TICKS 4'hd
`define AMS_SLOT_TICKS 2'h3
`define AMS_MAX_SLOTS_FOUR 3'h4
`define AMS_MAX_SLOTS_THREE 3'h3

`endif

// ===== hw/ams_pkg.sv
// Types shared by the input sequencer and its users
package ams_pkg;

  typedef enum logic [1:0] {
    AMS_IDLE = 2'b00,
    AMS_SLOT = 2'b01,
    AMS_TAIL = 2'b10
  } ams_state_t;

  typedef struct packed {
    logic [2:0] equationSelect;
    logic [1:0] chopMode;
    logic [1:0] filterLengthCode;
    logic firstPairDifferentialEnable;
    logic secondPairDifferentialEnable;
    logic halfRate;
    logic fastPll;
    logic remoteSensorEnable;
  } ams_cfg_t;

  typedef struct packed {
    logic active;
    logic [1:0] slot;
    logic [3:0] source;
  } ams_conv_t;

endpackage : ams_pkg

// ===== testbench/ams_slow_source.sv
// Slow frame clock source for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module ams_slow_source #(
  parameter int HalfNs = 100
) (
  output logic slowClock32k
);
  // Free running but faster than 32768 Hz so a frame fits a short run
  initial begin
    slowClock32k = 1'b0;
    #3;
    forever #HalfNs slowClock32k = ~slowClock32k;
  end
endmodule : ams_slow_source
`default_nettype wire

// ===== testbench/ams_sequencer_checker.sv
// Port assertions for the input sequencer
`timescale 1ns/1ps
`default_nettype none
module ams_sequencer_checker #(
  parameter bit FourInput = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slowClock32k,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWriteData,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioReadData,
  input wire ams_pkg::ams_conv_t conv,
  input wire logic frameStart,
  input wire logic slotStart,
  input wire ams_pkg::ams_cfg_t cfg
);
  import ams_pkg::*;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  always_comb begin
    next_cnt = (ioWrite && ioAddr == 16'h2100) ? ioWriteData[7:4] : cnt;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt <= 4'h0;
    else cnt <= next_cnt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  frame_begin_a: assert property (frameStart |-> slotStart && conv.active && conv.slot == 2'h0)
    else $error("frame did not open at first slot");
  slot_step_a: assert property (slotStart && !frameStart |-> conv.slot == $past(conv.slot) + 2'h1)
    else $error("slot did not advance by one");
  pulse_single_a: assert property (slotStart |=> !slotStart [*8])
    else $error("slot pulse too long or slots too close");
  slot_live_a: assert property (slotStart |-> conv.active)
    else $error("slot started without conversion");
  slot_cap_a: assert property (conv.active |-> FourInput || conv.slot != 2'h3)
    else $error("slot index beyond variant limit");
  equ_follow_a: assert property (ioWrite && ioAddr == 16'h2106 |=> cfg.equationSelect == $past(ioWriteData[7:5]))
    else $error("equation select not updated");
  remote_follow_a: assert property (ioWrite && ioAddr == 16'h2709 |=> cfg.remoteSensorEnable == $past(ioWriteData[3]))
    else $error("remote enable not updated");
  zero_idle_a: assert property (cnt == 4'h0 && $past(cnt) == 4'h0 && !$past(conv.active) |-> !frameStart)
    else $error("frame started with zero count");
endmodule : ams_sequencer_checker
bind ams_sequencer ams_sequencer_checker #(.FourInput(FourInput)) chk (.clk, .nrst, .slowClock32k, .ioAddr,
  .ioWriteData, .ioWrite, .ioRead, .ioReadData, .conv, .frameStart, .slotStart, .cfg);
`default_nettype wire

// ===== testbench/test_ams_sequencer.sv
// Self-checking bench for the input sequencer
`timescale 1ns/1ps
`default_nettype none
module test_ams_sequencer;
  import ams_pkg::*;
  localparam int FrameCyc = 13 * 20;
  localparam int SlotCyc = 3 * 20;
  logic clk, nrst, slowClock32k, ioWrite, ioRead, frameStart, slotStart;
  logic [15:0] ioAddr;
  logic [7:0] ioWriteData, ioReadData;
  ams_conv_t conv;
  ams_conv_t conv3;
  logic slotStart3;
  ams_cfg_t cfg;
  int errorCnt, nChecks, cyc, seen;
  logic [15:0] adr [7] = '{16'h2100, 16'h2105, 16'h2104, 16'h2106, 16'h210c, 16'h2200, 16'h2709};
  ams_sequencer #(.FourInput(1'b1)) dut (.clk, .nrst, .slowClock32k, .ioAddr, .ioWriteData, .ioWrite,
    .ioRead, .ioReadData, .conv, .frameStart, .slotStart, .cfg);
  // Three-input variant shares the bus, so its clipped frames run in step
  ams_sequencer #(.FourInput(1'b0)) dutThree (.clk, .nrst, .slowClock32k, .ioAddr, .ioWriteData, .ioWrite,
    .ioRead, .ioReadData(), .conv(conv3), .frameStart(), .slotStart(slotStart3), .cfg());
  ams_slow_source src (.slowClock32k);
  task automatic give_verdict;
    if (errorCnt == 0 && nChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    ioAddr <= a;
    ioWriteData <= d;
    ioWrite <= 1'b1;
    @(posedge clk);
    ioWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    ioAddr <= a;
    ioRead <= 1'b1;
    @(posedge clk);
    ioRead <= 1'b0;
    #1;
    cmp("read data", {8'h00, exp}, {8'h00, ioReadData});
  endtask : rd
  // Measures one whole frame: slot count, sources in order, length in clocks
  task automatic frame(input logic [2:0] n, input logic [15:0] srcs);
    int t;
    int act;
    int act3;
    logic [2:0] k;
    logic [2:0] k3;
    logic [2:0] n3;
    logic [15:0] got;
    #1;
    n3 = (n > 3'h3) ? 3'h3 : n;
    t = 0;
    while (frameStart !== 1'b1 && t < 600) begin
      @(posedge clk);
      #1;
      t++;
    end
    k = 3'h0;
    k3 = 3'h0;
    act = 0;
    act3 = 0;
    got = 16'h0;
    t = 0;
    do begin
      if (slotStart === 1'b1) begin
        got = {got[11:0], conv.source};
        k++;
      end
      if (slotStart3 === 1'b1) k3++;
      if (conv.active === 1'b1) act++;
      if (conv3.active === 1'b1) act3++;
      @(posedge clk);
      #1;
      t++;
    end while (frameStart !== 1'b1 && t < 600);
    cmp("frame length", 16'(FrameCyc), t[15:0]);
    cmp("slot count", {13'h0, n}, {13'h0, k});
    cmp("slot sources", srcs, got);
    cmp("active clocks", 16'(n * SlotCyc), act[15:0]);
    cmp("three-input slot count", {13'h0, n3}, {13'h0, k3});
    cmp("three-input active clocks", 16'(n3 * SlotCyc), act3[15:0]);
  endtask : frame
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      give_verdict();
    end
  end
  initial begin
    {nrst, ioWrite, ioRead, ioAddr, ioWriteData} = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (frameStart === 1'b1) seen++;
    end
    cmp("idle frames", 16'h0, 16'(seen));
    rd(16'h2101, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd(adr[i], 8'h00);
      wr(adr[i], 8'h5a ^ i[7:0]);
      rd(adr[i], 8'h5a ^ i[7:0]);
    end
    rd(16'h2102, 8'h00);
    frame(3'h4, 16'hb585);
    wr(16'h2100, 8'h00);
    wr(16'h2105, 8'ha0);
    wr(16'h2104, 8'h12);
    wr(16'h210c, 8'h32);
    wr(16'h2200, 8'h30);
    wr(16'h2106, 8'h20);
    wr(16'h2100, 8'h30);
    frame(3'h3, 16'h00a2);
    wr(16'h2100, 8'h00);
    wr(16'h2104, 8'h92);
    wr(16'h210c, 8'h34);
    wr(16'h2200, 8'h10);
    wr(16'h2106, 8'h40);
    wr(16'h2100, 8'h40);
    frame(3'h4, 16'h0a29);
    wr(16'h2100, 8'h00);
    wr(16'h2709, 8'h08);
    wr(16'h210c, 8'h12);
    wr(16'h2200, 8'h30);
    wr(16'h2104, 8'h19);
    wr(16'h2100, 8'h30);
    frame(3'h3, 16'h00a9);
    cmp("config", {4'h0, 3'h2, 2'h0, 2'h1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1}, {4'h0, cfg});
    give_verdict();
  end
endmodule : test_ams_sequencer
`default_nettype wire
